// [switch_global_control_storm_rate.sv]
// global switch control registers: port 3 mii, null vid, storm rate
`timescale 1ns/1ps
`default_nettype none
module switch_global_control_storm_rate
  import switch_global_pkg::*;
#(
  parameter int unsigned NPORTS       = 3,
  // interval lengths in clocks; shorten for simulation
  parameter int unsigned INTERVAL_100 = int'(STORM_T100_CYC),
  parameter int unsigned INTERVAL_10  = int'(STORM_T10_CYC)
) (
  input  wire logic                              clk,
  input  wire logic                              rst,
  // register access port
  input  wire logic [switch_global_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic                              reg_wr,
  input  wire logic [switch_global_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                              reg_rd,
  output logic [switch_global_pkg::DATA_W-1:0]   reg_rdata,
  output logic                                   reg_rvalid,
  // strap pins, sampled once after reset
  input  wire logic                              port1_led_strap_b,
  input  wire logic                              port1_flow_strap_pin,
  input  wire logic                              port3_speed_strap_pin,
  input  wire logic                              port1_speed_strap_pin,
  // mii configuration to the mac side
  output logic                                   port3_flow_en,
  output logic                                   port3_mii_10bt,
  output logic                                   port1_flow_en,
  output logic                                   port1_mii_10bt,
  // storm limiter, one lane per input port
  input  wire logic [NPORTS-1:0]                 link_10bt,
  input  wire logic [NPORTS-1:0]                 blk_valid,
  input  wire logic [NPORTS-1:0]                 blk_bcast,
  output logic [NPORTS-1:0]                      blk_drop,
  output logic [NPORTS-1:0]                      storm_spent,
  // vlan id path
  input  wire logic                              vid_valid,
  input  wire logic [switch_global_pkg::VID_W-1:0] vid_in,
  input  wire logic [switch_global_pkg::VID_W-1:0] port_vid,
  output logic                                   vid_out_valid,
  output logic [switch_global_pkg::VID_W-1:0]    vid_out
);
  import switch_global_pkg::*;

  ////////////////////////////////////////////////////////////////
  // declarations

  // strap capture
  logic              strap_done_q;   // straps taken, registers live

  // port 3 mii / storm high register fields
  logic              flow_en_q;      // full-duplex pause on port 3
  logic              mii_10bt_q;     // port 3 at 10 Mbps
  logic              null_vid_q;     // null vid substitution
  logic [2:0]        rate_hi_q;      // storm rate bits 10..8

  // storm rate low register
  logic [7:0]        rate_lo_q;      // storm rate bits 7..0

  // port 1 strap copies, no register behind them
  logic              p1_flow_q;      // port 1 pause enable
  logic              p1_10bt_q;      // port 1 at 10 Mbps

  // register read path
  logic [DATA_W-1:0] rdata_d;        // decoded read value
  logic [DATA_W-1:0] rdata_q;        // registered read value
  logic              rvalid_q;       // read answer strobe
  // factory test values are constants and need no storage

  // write decode strobes
  // both strobes come from the wr_hit helper below
  logic              wr_mii_hi;      // write to offset 0x06
  logic              wr_rate_lo;     // write to offset 0x07

  // carrier to the helpers
  cfg_if             cfg ();

  ////////////////////////////////////////////////////////////////
  // write decode

  // one offset hit by a write, only once the straps are in;
  // the gate keeps a write on the capture edge from racing the pins
  function automatic logic wr_hit(input logic                wr,
                                  input logic                live,
                                  input logic [ADDR_W-1:0]   addr,
                                  input logic [ADDR_W-1:0]   off);
    return wr && live && (addr == off);
  endfunction

  // factory test offsets have no strobe: writes are dropped
  assign wr_mii_hi  = wr_hit(reg_wr, strap_done_q, reg_addr, OFF_P3_MII_STORM_HI);
  assign wr_rate_lo = wr_hit(reg_wr, strap_done_q, reg_addr, OFF_STORM_RATE_LOW);

  ////////////////////////////////////////////////////////////////
  // strap capture

  // asynchronous reset may only load constants, so the pins
  // are caught by the first clock edge after release instead
  // and writes on that same edge are dropped by the decode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_done_q <= 1'b0;
    end else begin
      strap_done_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // port 3 flow control enable

  // pin is pulled up inside, so an open pin leaves pause on
  // software may override the strap from the second edge on
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flow_en_q <= RST_FLOW_EN;
    end else if (!strap_done_q) begin
      flow_en_q <= port1_led_strap_b;
    end else if (wr_mii_hi) begin
      flow_en_q <= reg_wdata[BIT_FLOW_EN];
    end
  end

  ////////////////////////////////////////////////////////////////
  // port 3 speed select

  // pin pulled down inside, so default is 100 Mbps
  // the strap sets the start value, a write may change it later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mii_10bt_q <= RST_MII_10BT;
    end else if (!strap_done_q) begin
      mii_10bt_q <= port3_speed_strap_pin;
    end else if (wr_mii_hi) begin
      mii_10bt_q <= reg_wdata[BIT_MII_10BT];
    end
  end

  ////////////////////////////////////////////////////////////////
  // port 1 strap copies

  // port 1 speed pin reads the other way round: high is 100
  // no register holds these, so only a fresh reset can change them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      p1_flow_q <= RST_FLOW_EN;
      p1_10bt_q <= RST_MII_10BT;
    end else if (!strap_done_q) begin
      p1_flow_q <= port1_flow_strap_pin;
      p1_10bt_q <= ~port1_speed_strap_pin;
    end
  end

  ////////////////////////////////////////////////////////////////
  // null vid replacement enable

  // no strap behind this bit, it starts off
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      null_vid_q <= RST_NULL_VID;
    end else if (wr_mii_hi) begin
      null_vid_q <= reg_wdata[BIT_NULL_VID];
    end
  end

  ////////////////////////////////////////////////////////////////
  // storm rate fields

  // default 0x063 is about one percent of min-size 100 Mbps load
  // the high bits share offset 0x06 with the mii bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rate_hi_q <= RST_RATE_HI;
    end else if (wr_mii_hi) begin
      rate_hi_q <= reg_wdata[RATE_HI_MSB:0];
    end
  end

  // the low byte has an offset of its own
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rate_lo_q <= RST_RATE_LOW;
    end else if (wr_rate_lo) begin
      rate_lo_q <= reg_wdata;
    end
  end

  // the two halves are written separately, so software sees a
  // short mixed rate between its two writes; harmless for storms
  // a careful driver writes the high half first when lowering

  ////////////////////////////////////////////////////////////////
  // read decode

  // bits 7 and 6 of offset 0x06 are reserved and read zero
  always_comb begin
    rdata_d = RDATA_UNMAPPED;
    unique case (reg_addr)
      OFF_P3_MII_STORM_HI: begin
        rdata_d[BIT_FLOW_EN]     = flow_en_q;
        rdata_d[BIT_MII_10BT]    = mii_10bt_q;
        rdata_d[BIT_NULL_VID]    = null_vid_q;
        rdata_d[RATE_HI_MSB:0]   = rate_hi_q;
      end
      OFF_STORM_RATE_LOW: begin
        rdata_d = rate_lo_q;
      end
      // factory test values are constants, nothing can move them
      OFF_FACTORY_TEST_A: begin
        rdata_d = RST_FACTORY_A;
      end
      OFF_FACTORY_TEST_B: begin
        rdata_d = RST_FACTORY_B;
      end
      OFF_FACTORY_TEST_C: begin
        rdata_d = RST_FACTORY_C;
      end
      default: begin
        rdata_d = RDATA_UNMAPPED;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // read answer, one clock after the strobe
  // data holds between reads, so a late look still finds it

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd;
      if (reg_rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;

  ////////////////////////////////////////////////////////////////
  // configuration outputs

  // mac side pause logic follows this level directly
  // port 1 results are pins only, software cannot read them
  assign port3_flow_en  = flow_en_q;
  assign port3_mii_10bt = mii_10bt_q;
  assign port1_flow_en  = p1_flow_q;
  assign port1_mii_10bt = p1_10bt_q;

  ////////////////////////////////////////////////////////////////
  // carrier drive

  // interval lengths are fixed at build time, not by software
  // eleven bit rate: three high bits above the low byte
  assign cfg.rate         = {rate_hi_q, rate_lo_q};
  assign cfg.interval_100 = INTERVAL_100[TIMER_W-1:0];
  assign cfg.interval_10  = INTERVAL_10[TIMER_W-1:0];
  assign cfg.null_vid_en  = null_vid_q;

  ////////////////////////////////////////////////////////////////
  // one storm limiter per input port

  // separate timers cost area but let each port keep its own
  // speed-dependent interval without a shared divider
  // a lane at its limit drops broadcast blocks only
  for (genvar p = 0; p < NPORTS; p++) begin : g_storm
    storm_port_limiter u_lim (
      .clk       (clk),
      .rst       (rst),
      .cfg       (cfg),
      .link_10bt (link_10bt[p]),
      .blk_valid (blk_valid[p]),
      .blk_bcast (blk_bcast[p]),
      .blk_drop  (blk_drop[p]),
      .spent     (storm_spent[p])
    );
  end

  ////////////////////////////////////////////////////////////////
  // null vid substitution on the tag path
  // one clock of latency, valid travels with the id

  null_vid_replacer u_vid (
    .clk           (clk),
    .rst           (rst),
    .cfg           (cfg),
    .vid_valid     (vid_valid),
    .vid_in        (vid_in),
    .port_vid      (port_vid),
    .vid_out_valid (vid_out_valid),
    .vid_out       (vid_out)
  );

endmodule // switch_global_control_storm_rate
`default_nettype wire

// [switch_global_pkg.sv]
// shared constants for the global control and storm rate register bank
`default_nettype none
package switch_global_pkg;
  // register port, storm rate, vid and timer widths
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned RATE_W   = 11;
  localparam int unsigned VID_W    = 12;
  localparam int unsigned TIMER_W  = 24;
  // register offsets
  localparam logic [7:0] OFF_P3_MII_STORM_HI = 8'h06;
  localparam logic [7:0] OFF_STORM_RATE_LOW  = 8'h07;
  localparam logic [7:0] OFF_FACTORY_TEST_A  = 8'h08;
  localparam logic [7:0] OFF_FACTORY_TEST_B  = 8'h09;
  localparam logic [7:0] OFF_FACTORY_TEST_C  = 8'h0A;
  // field positions in the port 3 mii / storm high register
  localparam int unsigned BIT_FLOW_EN    = 5;
  localparam int unsigned BIT_MII_10BT   = 4;
  localparam int unsigned BIT_NULL_VID   = 3;
  localparam int unsigned RATE_HI_MSB    = 2;
  // reset values
  localparam logic [2:0] RST_RATE_HI     = 3'h0;
  localparam logic [7:0] RST_RATE_LOW    = 8'h63;
  localparam logic       RST_NULL_VID    = 1'b0;
  localparam logic       RST_FLOW_EN     = 1'b1;
  localparam logic       RST_MII_10BT    = 1'b0;
  localparam logic [7:0] RST_FACTORY_A   = 8'h00;
  localparam logic [7:0] RST_FACTORY_B   = 8'h24;
  localparam logic [7:0] RST_FACTORY_C   = 8'h35;
  localparam logic [7:0] RDATA_UNMAPPED  = 8'h00;
  // storm interval timing at the 20 MHz system clock
  localparam longint CLK_HZ             = 20_000_000;
  localparam longint STORM_T100_MS      = 67;
  localparam longint STORM_T10_MS       = 500;
  localparam longint STORM_T100_CYC     = STORM_T100_MS * CLK_HZ / 1000;
  localparam longint STORM_T10_CYC      = STORM_T10_MS * CLK_HZ / 1000;
  // true once a port has used up its block allowance
  function automatic logic rate_spent(input logic [RATE_W-1:0] cnt,
                                      input logic [RATE_W-1:0] rate);
    return cnt >= rate;
  endfunction
endpackage
`default_nettype wire

// [cfg_if.sv]
// configuration carrier from the register bank to its helper modules
`timescale 1ns/1ps
`default_nettype none
interface cfg_if;
  logic [10:0] rate;          // storm allowance in 64-byte blocks
  logic [23:0] interval_100;  // interval length, 100 Mbps links
  logic [23:0] interval_10;   // interval length, 10 Mbps links
  logic        null_vid_en;   // substitute port vid for null vid
  modport src  (output rate, output interval_100, output interval_10, output null_vid_en);
  modport sink (input rate, input interval_100, input interval_10, input null_vid_en);
endinterface
`default_nettype wire

// [storm_port_limiter.sv]
// per-port broadcast block counter with its own interval timer
`timescale 1ns/1ps
`default_nettype none
module storm_port_limiter
  import switch_global_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  cfg_if.sink              cfg,
  input  wire logic        link_10bt,  // port runs at 10 Mbps
  input  wire logic        blk_valid,  // one 64-byte block offered
  input  wire logic        blk_bcast,  // block belongs to broadcast frame
  output logic             blk_drop,   // discard this block
  output logic             spent       // allowance used up this interval
);
  logic [TIMER_W-1:0] timer_q;  // cycles left in interval
  logic [RATE_W-1:0]  cnt_q;    // broadcast blocks passed this interval
  logic               wrap;     // interval ends this cycle

  assign wrap     = (timer_q == '0);
  assign spent    = rate_spent(cnt_q, cfg.rate);
  // full allowance means broadcast data goes to the floor
  assign blk_drop = blk_valid & blk_bcast & spent;

  ////////////////////////////////////////////////////////////////
  // interval timer, length follows the port speed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_q <= '0;
    end else if (wrap) begin
      timer_q <= (link_10bt ? cfg.interval_10 : cfg.interval_100) - 24'h000001;
    end else begin
      timer_q <= timer_q - 24'h000001;
    end
  end

  ////////////////////////////////////////////////////////////////
  // block counter; clear at interval start wins over a block
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (wrap) begin
      cnt_q <= '0;
    end else if (blk_valid && blk_bcast && !spent) begin
      cnt_q <= cnt_q + 11'h001;
    end
  end
endmodule // storm_port_limiter
`default_nettype wire

// [null_vid_replacer.sv]
// swaps a null vlan id for the port default vid, one cycle latency
`timescale 1ns/1ps
`default_nettype none
module null_vid_replacer
  import switch_global_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  cfg_if.sink                   cfg,
  input  wire logic             vid_valid,
  input  wire logic [VID_W-1:0] vid_in,
  input  wire logic [VID_W-1:0] port_vid,
  output logic                  vid_out_valid,
  output logic [VID_W-1:0]      vid_out
);
  ////////////////////////////////////////////////////////////////
  // registered substitution
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vid_out_valid <= 1'b0;
      vid_out       <= '0;
    end else begin
      vid_out_valid <= vid_valid;
      if (vid_valid) begin
        // null id kept as is unless replacement enabled
        vid_out <= (cfg.null_vid_en && vid_in == '0) ? port_vid : vid_in;
      end
    end
  end
endmodule // null_vid_replacer
`default_nettype wire

// [switch_global_chk.sv]
// concurrent checks on the ports of the global control and storm rate bank
`timescale 1ns/1ps
`default_nettype none
module switch_global_chk
  import switch_global_pkg::*;
#(
  parameter int unsigned NPORTS       = 3,
  parameter int unsigned INTERVAL_100 = 20,
  parameter int unsigned INTERVAL_10  = 40
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [7:0]        reg_addr,
  input wire logic              reg_wr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_rdata,
  input wire logic              reg_rvalid,
  input wire logic              port1_led_strap_b,
  input wire logic              port3_speed_strap_pin,
  input wire logic              port1_speed_strap_pin,
  input wire logic              port1_mii_10bt,
  input wire logic              port3_flow_en,
  input wire logic              port3_mii_10bt,
  input wire logic [NPORTS-1:0] blk_valid,
  input wire logic [NPORTS-1:0] blk_bcast,
  input wire logic [NPORTS-1:0] blk_drop,
  input wire logic [NPORTS-1:0] storm_spent,
  input wire logic              vid_valid,
  input wire logic [11:0]       vid_in,
  input wire logic              vid_out_valid,
  input wire logic [11:0]       vid_out
);
  // one clock domain, reset disables everything
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // write to the mii register, not on the strap capture edge
  sequence s_wr_mii;
    reg_wr && reg_addr == 8'h06 && !$past(rst);
  endsequence
  // vid that is not null passes untouched
  sequence s_vid_plain;
    vid_valid && vid_in != 12'h000;
  endsequence
  // lane 0 spent flag rising
  sequence s_spent_rise;
    $rose(storm_spent[0]);
  endsequence
  // a broadcast block or any register write just before
  sequence s_spent_why;
    $past(blk_valid[0] && blk_bcast[0]) || $past(reg_wr);
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read without answer");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without read");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  a_factory_fixed: assert property (reg_rd && reg_addr == 8'h09 |=> reg_rdata == 8'h24)
    else $error("factory register changed");
  a_flow_write: assert property (s_wr_mii |=> port3_flow_en == $past(reg_wdata[5]))
    else $error("flow enable not following write");
  a_speed_write: assert property (s_wr_mii |=> port3_mii_10bt == $past(reg_wdata[4]))
    else $error("speed select not following write");
  a_p1_speed_strap: assert property ($fell(rst) |=> port1_mii_10bt == !$past(port1_speed_strap_pin))
    else $error("port 1 speed strap polarity");
  a_flow_strap: assert property ($fell(rst) |=> port3_flow_en == $past(port1_led_strap_b))
    else $error("flow enable not taken from strap");
  a_speed_strap: assert property ($fell(rst) |=> port3_mii_10bt == $past(port3_speed_strap_pin))
    else $error("port 3 speed strap polarity");
  a_spent_cause: assert property (s_spent_rise |-> s_spent_why)
    else $error("spent rose without block or rate write");
  a_drop_rule: assert property (blk_drop == (blk_valid & blk_bcast & storm_spent))
    else $error("drop not tied to spent broadcast");
  a_vid_pass: assert property (s_vid_plain |=> vid_out_valid && vid_out == $past(vid_in))
    else $error("non-null vid altered");
endmodule // switch_global_chk
// attach beside every instance of the bank
bind switch_global_control_storm_rate switch_global_chk #(.NPORTS(NPORTS),
  .INTERVAL_100(INTERVAL_100), .INTERVAL_10(INTERVAL_10)) u_chk (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .port1_led_strap_b(port1_led_strap_b), .port3_speed_strap_pin(port3_speed_strap_pin),
  .port1_speed_strap_pin(port1_speed_strap_pin), .port1_mii_10bt(port1_mii_10bt),
  .port3_flow_en(port3_flow_en), .port3_mii_10bt(port3_mii_10bt),
  .blk_valid(blk_valid), .blk_bcast(blk_bcast), .blk_drop(blk_drop),
  .storm_spent(storm_spent), .vid_valid(vid_valid), .vid_in(vid_in),
  .vid_out_valid(vid_out_valid), .vid_out(vid_out));
`default_nettype wire

// [switch_global_control_storm_rate_test.sv]
// self-checking bench for the global control and storm rate bank
`timescale 1ns/1ps
`default_nettype none
module switch_global_control_storm_rate_test;
  import switch_global_pkg::*;
  localparam int N100 = 20;         // short intervals keep the run brief
  localparam int N10  = 40;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic        reg_wr = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata, w;
  logic        reg_rvalid;
  logic [3:0]  strap = 4'h0;        // led, flow pin, p3 speed, p1 speed
  logic        p3_flow, p3_10bt, p1_flow, p1_10bt;
  logic [2:0]  link_10bt = 3'h0;
  logic [2:0]  blk_valid = 3'h0;
  logic [2:0]  blk_bcast = 3'h0;
  logic [2:0]  blk_drop, storm_spent;
  logic        vid_valid = 1'b0;
  logic [11:0] vid_in = 12'h000;
  logic [11:0] port_vid = 12'h000;
  logic        vid_out_valid;
  logic [11:0] vid_out;
  logic [7:0]  fac [3] = '{8'h00, 8'h24, 8'h35};  // fixed factory values
  int          error_cnt = 0;
  int          cmp_count = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // 20 MHz system clock
  always #25 clk = ~clk;
  switch_global_control_storm_rate #(.NPORTS(3), .INTERVAL_100(N100), .INTERVAL_10(N10))
  u_switch_global_control_storm_rate (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .port1_led_strap_b(strap[3]),
    .port1_flow_strap_pin(strap[2]), .port3_speed_strap_pin(strap[1]),
    .port1_speed_strap_pin(strap[0]), .port3_flow_en(p3_flow), .port3_mii_10bt(p3_10bt),
    .port1_flow_en(p1_flow), .port1_mii_10bt(p1_10bt), .link_10bt(link_10bt),
    .blk_valid(blk_valid), .blk_bcast(blk_bcast), .blk_drop(blk_drop),
    .storm_spent(storm_spent), .vid_valid(vid_valid), .vid_in(vid_in),
    .port_vid(port_vid), .vid_out_valid(vid_out_valid), .vid_out(vid_out));
  ////////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // readable bits of the mii register, top two read zero
  function automatic logic [7:0] r6_exp(input logic [7:0] v);
    return v & 8'h3F;
  endfunction
  // one write strobe, held for exactly one sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  // one read strobe, answer looked at in its single valid cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    chk({15'h0, reg_rvalid}, 16'h0001);
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask
  // one vid through the replacer
  task automatic vid(input logic nv, input logic [11:0] v);
    logic [11:0] pv;
    pv = 12'($urandom);
    wr(OFF_P3_MII_STORM_HI, {4'h0, nv, 3'h0});
    @(posedge clk);
    vid_valid <= 1'b1;
    vid_in    <= v;
    port_vid  <= pv;
    @(posedge clk);
    vid_valid <= 1'b0;
    @(negedge clk);
    chk({3'h0, vid_out_valid, vid_out}, {4'h1, (nv && v == 12'h000) ? pv : v});
  endtask
  // bounded wait for a lane's spent flag; a miss shows as a mismatch
  task automatic wait_spent(input int l, input logic v);
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (storm_spent[l] !== v && k < 100);
    chk({15'h0, storm_spent[l]}, {15'h0, v});
  endtask
  // one full interval: r blocks let through, then spent till the wrap
  task automatic storm(input int l, input int r);
    int lo, hi, n;
    n = link_10bt[l] ? N10 : N100;
    wr(OFF_STORM_RATE_LOW, r[7:0]);
    // two intervals skipped so the new rate and speed have settled
    repeat (2) begin
      wait_spent(l, 1'b1);
      wait_spent(l, 1'b0);
    end
    lo = 0;
    hi = 0;
    while (storm_spent[l] === 1'b0 && lo < 100) begin
      lo++;
      @(negedge clk);
    end
    while (storm_spent[l] === 1'b1 && hi < 100) begin
      hi++;
      @(negedge clk);
    end
    chk(16'(lo), 16'(r));
    chk(16'(hi), 16'(n - r));
  endtask
  // steady spent level over more than one long interval
  task automatic phase(input logic [2:0] bc, input logic [2:0] exp);
    @(posedge clk);
    blk_bcast <= bc;
    repeat (45) @(posedge clk);
    repeat (45) begin
      @(negedge clk);
      chk({13'h0, storm_spent}, {13'h0, exp});
      chk({13'h0, blk_drop}, {13'h0, exp & bc});
    end
  endtask
  // verdict and end of run
  task automatic end_of_test();
    if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the fewer than one thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
  // main sequence
  initial begin
    void'($urandom(32'h708E2CC2));
    strap     = 4'($urandom);
    link_10bt = {1'($urandom), 2'b10};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk(16'({p3_flow, p3_10bt, p1_flow, p1_10bt}), 16'({strap[3], strap[1], strap[2], ~strap[0]}));
    rd(OFF_P3_MII_STORM_HI, {2'b00, strap[3], strap[1], 4'h0});
    rd(OFF_STORM_RATE_LOW, 8'h63);
    for (int i = 0; i < 3; i++) begin
      wr(8'h08 + 8'(i), 8'($urandom));
      rd(8'h08 + 8'(i), fac[i]);
    end
    w = 8'h0B + 8'($urandom_range(0, 244));
    wr(w, 8'hFF);
    rd(w, 8'h00);
    for (int i = 0; i < 10; i++) begin
      w = (i < 2) ? {2'b00, 1'(i), ~1'(i), 4'h0} : 8'($urandom);
      wr(OFF_P3_MII_STORM_HI, w);
      @(negedge clk);
      chk(16'({p3_flow, p3_10bt}), 16'({w[5], w[4]}));
      rd(OFF_P3_MII_STORM_HI, r6_exp(w));
    end
    vid(1'b1, 12'h000);
    vid(1'b1, 12'($urandom_range(1, 4095)));
    vid(1'b0, 12'h000);
    @(posedge clk);
    blk_valid <= 3'h7;
    blk_bcast <= 3'h7;
    for (int l = 0; l < 3; l++) storm(l, $urandom_range(1, 15));
    phase(3'h0, 3'h0);
    wr(OFF_P3_MII_STORM_HI, 8'h01);
    phase(3'h7, 3'h0);
    wr(OFF_P3_MII_STORM_HI, 8'h00);
    wr(OFF_STORM_RATE_LOW, 8'h00);
    phase(3'h7, 3'h7);
    end_of_test();
  end
endmodule // switch_global_control_storm_rate_test
`default_nettype wire
